//--- fpc_panel.sv
// front panel output control: keys, display sequencing, power-up state, serial rx
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RL1] enable key toggles output; off or value shown
// [RL2] output starts disabled after power-up
// [RL3] keys step thirteen fixed ranges plus user
// [RL4] up from 100 mA selects user range
// [RL5] stepping saturates at both ends
// [RL6] enabled fixed range flashes 3 s first
// [RL7] user: label once, value twice, then apply
// [RL8] host range change applies with no delay
// [RL9] disabled: show range 1 s, then off
// [RL10] range chosen while disabled is stored
// [RL11] separate polarity for fixed and user ranges
// [RL12] polarity key acts at once
// [RL13] user current 100 nA..100 mA, three digits
// [RL14] power-up enable option restores previous enable
// [RL15] pol hold 3 s saves power-up state
// [RL16] factory reset rewrites saved state to defaults
// [RL17] enable hold 3 s locks keypad
// [RL18] locked press shows locked message 1 s
// [RL19] enable hold 3 s while locked unlocks
// [RL20] factory defaults: off, 100 nA, positive, unlocked
// [RL21] serial link 57600, 7 data, odd, 1 stop
// [RL22] keys debounced, holds timed from press onset
module fpc_panel
  import fpc_pkg::*;
#(
  parameter int unsigned P_HOLD_CYC  = HOLD_CYC,
  parameter int unsigned P_MSG_CYC   = MSG_CYC,
  parameter int unsigned P_FLASH_CYC = FLASH_CYC,
  parameter int unsigned P_DEB_CYC   = DEB_CYC
)(
  input  wire logic      I_CLK,
  input  wire logic      I_RST_N,
  input  wire logic      I_KEY_ENABLE,
  input  wire logic      I_KEY_UP,
  input  wire logic      I_KEY_DOWN,
  input  wire logic      I_KEY_POL,
  input  wire fpc_host_t I_HOST,
  input  wire fpc_nv_t   I_NV_STATE,
  input  wire logic      I_NV_PWUP_OPT,
  input  wire logic      I_FACTORY_RESET,
  input  wire logic      I_SER_RX,
  output logic           O_OUT_ENABLE,
  output logic [3:0]     O_OUT_RANGE,
  output logic           O_OUT_NEG,
  output fpc_cur_t       O_USER_CUR,
  output fpc_disp_t      O_DISP,
  output logic           O_LOCKED,
  output logic           O_PWUP_OPT,
  output logic           O_NV_WR,
  output fpc_nv_t        O_NV_DATA,
  output logic [6:0]     O_RX_DATA,
  output logic           O_RX_VALID,
  output logic           O_RX_ERR
);
  if (P_MSG_CYC < 2 || P_HOLD_CYC < 2 || P_FLASH_CYC < 2 || P_DEB_CYC < 1)
    $error("fpc_panel: timing counts too small");

  function automatic logic [3:0] step(input logic [3:0] r, input logic up);
    if (up)
      step = (r == RNG_USER) ? r : r + 4'h1; // [RL4] [RL5]
    else
      step = (r == RNG_MIN) ? r : r - 4'h1; // [RL5]
  endfunction

  function automatic logic cur_ok(input fpc_cur_t c);
    cur_ok = c.mant >= MANT_MIN && c.mant <= MANT_MAX && c.exp <= EXP_MAX
             && !(c.exp == EXP_MAX && c.mant != MANT_MIN); // [RL13]
  endfunction

  logic [3:0]  keys;
  logic [3:0]  press;
  logic [3:0]  hold;
  logic        loaded;
  logic        locked;
  logic        out_en;
  logic        en_prev;
  logic [3:0]  sel_rng;
  logic [3:0]  out_rng;
  logic        pol_fixed;
  fpc_cur_t    user;
  logic        pwup_opt;
  fpc_nv_t     saved;
  fpc_state_t  state;
  fpc_state_t  st_prev;
  logic [31:0] timer;
  logic [31:0] blink_cnt;
  logic        blink_on;
  fpc_msg_t    note;
  logic        keys_ok;
  logic        rng_req;
  logic [3:0]  new_rng;
  logic        h_rng;
  logic        h_en;
  logic        h_op;

  assign keys = {I_KEY_POL, I_KEY_DOWN, I_KEY_UP, I_KEY_ENABLE};

  for (genvar k = 0; k < 4; k++)
  begin : g_key
    fpc_key #(.DEB(P_DEB_CYC), .HOLD(P_HOLD_CYC)) u_key (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_key   (keys[k]),
      .o_press (press[k]),
      .o_hold  (hold[k])
    );
  end

  assign keys_ok = loaded && !locked;
  assign rng_req = keys_ok && (press[K_UP] || press[K_DN]); // [RL3]
  assign new_rng = step(sel_rng, press[K_UP]);
  assign h_op    = loaded && I_HOST.valid;
  assign h_rng   = h_op && I_HOST.op == OP_RANGE && I_HOST.arg[3:0] <= RNG_USER;
  assign h_en    = h_op && I_HOST.op == OP_ENABLE;

  // stored state is only caught after reset release, never under it
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      loaded <= 1'b0;
    else
      loaded <= 1'b1;
  end

  // lock state
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      locked <= RST_LOCK; // [RL20]
    else if (h_op && I_HOST.op == OP_LOCK)
      locked <= I_HOST.arg[0];
    else if (loaded && hold[K_EN])
      locked <= !locked; // [RL17] [RL19]
  end

  // sequencing of enable, range and timed display
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state   <= ST_IDLE;
      timer   <= 32'h0;
      out_en  <= 1'b0; // [RL2]
      sel_rng <= RST_NV.range;
      out_rng <= RST_NV.range;
      note    <= MSG_LOCKED;
    end
    else if (!loaded)
    begin
      sel_rng <= I_NV_STATE.range;
      out_rng <= I_NV_STATE.range;
      out_en  <= I_NV_PWUP_OPT && I_NV_STATE.en; // [RL2] [RL14]
    end
    else if (h_rng)
    begin
      sel_rng <= I_HOST.arg[3:0]; // [RL8]
      out_rng <= I_HOST.arg[3:0];
      state   <= ST_IDLE;
    end
    else if (h_en)
    begin
      out_en  <= I_HOST.arg[0];
      out_rng <= sel_rng;
      state   <= ST_IDLE;
    end
    else if (hold[K_EN])
    begin
      state <= ST_MSG;
      timer <= P_MSG_CYC;
      note  <= locked ? MSG_UNLOCKED : MSG_LOCKED; // [RL17] [RL19]
    end
    else if (locked && (|press))
    begin
      state <= ST_MSG; // [RL18]
      timer <= P_MSG_CYC;
      note  <= MSG_LOCKED;
    end
    else if (keys_ok && press[K_EN])
    begin
      out_en  <= !out_en; // [RL1]
      out_rng <= sel_rng; // [RL10]
      state   <= ST_IDLE;
    end
    else if (rng_req)
    begin
      sel_rng <= new_rng;
      if (!out_en)
        out_rng <= new_rng; // [RL10]
      if (new_rng == RNG_USER)
      begin
        state <= ST_ULBL; // [RL7] [RL9]
        timer <= P_MSG_CYC;
      end
      else
      begin
        state <= ST_RNG;
        timer <= out_en ? P_FLASH_CYC : P_MSG_CYC; // [RL6] [RL9]
      end
    end
    else if (state != ST_IDLE)
    begin
      if (timer == 32'h1)
      begin
        case (state)
          ST_RNG:
          begin
            out_rng <= sel_rng; // [RL6]
            state   <= ST_IDLE;
          end
          ST_ULBL:
          begin
            if (out_en)
            begin
              state <= ST_UVAL; // [RL7]
              timer <= 2 * P_MSG_CYC;
            end
            else
              state <= ST_IDLE; // [RL9]
          end
          ST_UVAL:
          begin
            out_rng <= sel_rng; // [RL7]
            state   <= ST_IDLE;
          end
          default:
            state <= ST_IDLE;
        endcase
      end
      else
        timer <= timer - 32'h1;
    end
  end

  // polarity and user current
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pol_fixed <= RST_NV.pol_fixed;
      user      <= RST_USER;
    end
    else if (!loaded)
    begin
      pol_fixed <= I_NV_STATE.pol_fixed;
      user      <= I_NV_STATE.user;
    end
    else if (h_op && I_HOST.op == OP_USER && cur_ok(fpc_cur_t'(I_HOST.arg[13:0])))
      user <= fpc_cur_t'(I_HOST.arg[13:0]); // [RL13]
    else if (h_op && I_HOST.op == OP_POL)
    begin
      if (sel_rng == RNG_USER)
        user.neg <= I_HOST.arg[0];
      else
        pol_fixed <= I_HOST.arg[0];
    end
    else if (keys_ok && press[K_POL])
    begin
      if (sel_rng == RNG_USER)
        user.neg <= !user.neg; // [RL11] [RL12]
      else
        pol_fixed <= !pol_fixed; // [RL11] [RL12]
    end
  end

  // saved power-up state and its write strobe
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      saved    <= RST_NV;
      pwup_opt <= 1'b0;
      en_prev  <= 1'b0;
      O_NV_WR  <= 1'b0;
    end
    else if (!loaded)
    begin
      saved    <= I_NV_STATE;
      pwup_opt <= I_NV_PWUP_OPT;
      en_prev  <= I_NV_PWUP_OPT && I_NV_STATE.en;
      O_NV_WR  <= 1'b0;
    end
    else
    begin
      en_prev <= out_en;
      O_NV_WR <= 1'b0;
      if (h_op && I_HOST.op == OP_PWUP)
        pwup_opt <= I_HOST.arg[0]; // [RL14]
      if (I_FACTORY_RESET)
      begin
        saved   <= RST_NV; // [RL16] [RL20]
        O_NV_WR <= 1'b1;
      end
      else if ((keys_ok && hold[K_POL]) || (h_op && I_HOST.op == OP_SAVE))
      begin
        saved   <= '{range: sel_rng, pol_fixed: pol_fixed, user: user, en: out_en}; // [RL15]
        O_NV_WR <= 1'b1;
      end
      else if (out_en != en_prev)
      begin
        saved.en <= out_en; // [RL14]
        O_NV_WR  <= 1'b1;
      end
    end
  end

  // flash timing restarts on every state entry so each flash is whole
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      st_prev   <= ST_IDLE;
      blink_cnt <= 32'h0;
      blink_on  <= 1'b1;
    end
    else
    begin
      st_prev <= state;
      if (state != st_prev || blink_cnt == P_MSG_CYC / 2 - 1)
      begin
        blink_cnt <= 32'h0;
        blink_on  <= (state != st_prev) ? 1'b1 : !blink_on;
      end
      else
        blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // registered outputs
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_OUT_NEG <= 1'b0;
      O_DISP    <= '{msg: MSG_OFF, lit: 1'b1, range: RNG_MIN};
    end
    else
    begin
      O_OUT_NEG    <= (out_rng == RNG_USER) ? user.neg : pol_fixed; // [RL11]
      O_DISP.range <= sel_rng;
      // first cycle of a new state shows lit, before blink_on has restarted
      O_DISP.lit   <= (state == ST_IDLE || state == ST_MSG || state != st_prev) ? 1'b1 : blink_on;
      case (state)
        ST_RNG:  O_DISP.msg <= MSG_RANGE;
        ST_ULBL: O_DISP.msg <= MSG_USER;
        ST_UVAL: O_DISP.msg <= MSG_USERVAL;
        ST_MSG:  O_DISP.msg <= note;
        default: O_DISP.msg <= out_en ? MSG_VALUE : MSG_OFF; // [RL1]
      endcase
    end
  end

  assign O_OUT_ENABLE = out_en;
  assign O_OUT_RANGE  = out_rng;
  assign O_USER_CUR   = user;
  assign O_LOCKED     = locked;
  assign O_PWUP_OPT   = pwup_opt;
  assign O_NV_DATA    = saved;

  // serial receiver, start + 7 data + odd parity + stop, mid-bit sampling
  logic        rx_busy;
  logic [3:0]  rx_bit;
  logic [11:0] rx_tmr;
  logic [6:0]  rx_sh;
  logic        rx_par;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rx_busy    <= 1'b0;
      rx_bit     <= 4'h0;
      rx_tmr     <= 12'h0;
      rx_sh      <= 7'h00;
      rx_par     <= 1'b0;
      O_RX_DATA  <= 7'h00;
      O_RX_VALID <= 1'b0;
      O_RX_ERR   <= 1'b0;
    end
    else
    begin
      O_RX_VALID <= 1'b0;
      O_RX_ERR   <= 1'b0;
      if (!rx_busy)
      begin
        if (!I_SER_RX)
        begin
          rx_busy <= 1'b1;
          rx_bit  <= 4'h0;
          rx_tmr  <= 12'(BIT_CYC / 2);
        end
      end
      else if (rx_tmr != 12'h0)
        rx_tmr <= rx_tmr - 12'h1;
      else
      begin
        rx_tmr <= 12'(BIT_CYC - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && I_SER_RX)
          rx_busy <= 1'b0; // glitch, not a start bit
        else if (rx_bit >= 4'h1 && rx_bit <= 4'(SER_BITS))
          rx_sh <= {I_SER_RX, rx_sh[6:1]}; // [RL21]
        else if (rx_bit == 4'(SER_BITS + 1))
          rx_par <= I_SER_RX;
        else if (rx_bit == 4'(SER_BITS + 2))
        begin
          rx_busy    <= 1'b0;
          O_RX_DATA  <= rx_sh;
          O_RX_VALID <= I_SER_RX && (^{rx_sh, rx_par}); // [RL21]
          O_RX_ERR   <= !(I_SER_RX && (^{rx_sh, rx_par}));
        end
      end
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_user_pick;
    rng_req && new_rng == RNG_USER && out_en && !h_rng && !h_en && !hold[K_EN]
      && !press[K_EN];
  endsequence
  sequence s_user_flow;
    state == ST_ULBL && timer == P_MSG_CYC;
  endsequence

  a_powerup_off: assert property (!loaded |=> !out_en || pwup_opt) // [RL2]
    else $error("output enabled at power-up without option");
  a_enable_toggle: assert property (keys_ok && press[K_EN] && !h_rng && !h_en // [RL1]
    && !hold[K_EN] |=> out_en != $past(out_en))
    else $error("enable press did not toggle output");
  a_up_to_user: assert property (rng_req && press[K_UP] && sel_rng == RNG_TOP_FIXED // [RL4]
    && !press[K_EN] && !h_rng && !h_en && !hold[K_EN] |=> sel_rng == RNG_USER)
    else $error("up from top fixed range missed user range");
  a_range_sat: assert property (rng_req && !h_rng // [RL5]
    && ((press[K_UP] && sel_rng == RNG_USER) || (!press[K_UP] && sel_rng == RNG_MIN))
    |=> $stable(sel_rng))
    else $error("range stepping wrapped");
  a_flash_hold: assert property (state == ST_RNG && out_en && timer > 1 && !h_rng // [RL6]
    && !h_en && !press[K_EN] |=> $stable(out_rng))
    else $error("range applied before flash ended");
  a_user_flow: assert property (s_user_pick |=> s_user_flow) // [RL7]
    else $error("user pick did not show user label for one second");
  a_host_now: assert property (h_rng |=> out_rng == $past(I_HOST.arg[3:0])) // [RL8]
    else $error("host range change was delayed");
  a_locked_freeze: assert property (locked && loaded && (|press) && !h_op // [RL18]
    && !hold[K_EN] |=> $stable(sel_rng) && $stable(out_en) && state == ST_MSG
    ##1 O_DISP.msg == MSG_LOCKED)
    else $error("locked press changed settings");
  a_pol_now: assert property (keys_ok && press[K_POL] && sel_rng != RNG_USER && !h_op // [RL11]
    |=> pol_fixed != $past(pol_fixed) && $stable(user.neg))
    else $error("fixed polarity press misbehaved");
  a_save_strobe: assert property (keys_ok && hold[K_POL] && !I_FACTORY_RESET // [RL15]
    |=> O_NV_WR && O_NV_DATA.range == $past(sel_rng))
    else $error("polarity hold did not save state");
endmodule
`default_nettype wire

//--- fpc_pkg.sv
// shared constants and types of the front panel control block
package fpc_pkg;
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned HOLD_S      = 3;
  localparam int unsigned MSG_S       = 1;
  localparam int unsigned FLASH_RNG_S = 3;
  localparam int unsigned DEB_MS      = 10;
  localparam int unsigned BAUD        = 57_600;
  localparam int unsigned HOLD_CYC    = HOLD_S * CLK_HZ;
  localparam int unsigned MSG_CYC     = MSG_S * CLK_HZ;
  localparam int unsigned FLASH_CYC   = FLASH_RNG_S * CLK_HZ;
  localparam int unsigned DEB_CYC     = DEB_MS * (CLK_HZ / 1000);
  localparam int unsigned BIT_CYC     = CLK_HZ / BAUD;
  localparam int unsigned SER_BITS    = 7;
  localparam int unsigned NUM_FIXED   = 13;

  localparam logic [3:0] RNG_MIN       = 4'h0;
  localparam logic [3:0] RNG_TOP_FIXED = 4'hC;
  localparam logic [3:0] RNG_USER      = 4'hD;
  localparam logic [9:0] MANT_MIN      = 10'h064;
  localparam logic [9:0] MANT_MAX      = 10'h3E7;
  localparam logic [2:0] EXP_MAX       = 3'h6;

  // current magnitude = mant * 10^exp nA, mant 100..999
  typedef struct packed {
    logic       neg;
    logic [2:0] exp;
    logic [9:0] mant;
  } fpc_cur_t;

  typedef struct packed {
    logic [3:0] range;
    logic       pol_fixed;
    fpc_cur_t   user;
    logic       en;
  } fpc_nv_t;

  localparam fpc_cur_t RST_USER = '{neg: 1'b0, exp: 3'h0, mant: MANT_MIN};
  localparam fpc_nv_t  RST_NV   = '{range: RNG_MIN, pol_fixed: 1'b0,
                                    user: RST_USER, en: 1'b0};
  localparam logic     RST_LOCK = 1'b0;

  typedef enum logic [2:0] {
    OP_RANGE  = 3'h0,
    OP_ENABLE = 3'h1,
    OP_POL    = 3'h2,
    OP_USER   = 3'h3,
    OP_PWUP   = 3'h4,
    OP_LOCK   = 3'h5,
    OP_SAVE   = 3'h6
  } fpc_op_t;

  typedef struct packed {
    logic        valid;
    fpc_op_t     op;
    logic [15:0] arg;
  } fpc_host_t;

  typedef enum logic [2:0] {
    MSG_OFF      = 3'h0,
    MSG_VALUE    = 3'h1,
    MSG_RANGE    = 3'h2,
    MSG_USER     = 3'h3,
    MSG_USERVAL  = 3'h4,
    MSG_LOCKED   = 3'h5,
    MSG_UNLOCKED = 3'h6
  } fpc_msg_t;

  typedef struct packed {
    fpc_msg_t   msg;
    logic       lit;
    logic [3:0] range;
  } fpc_disp_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RNG  = 5'h02,
    ST_ULBL = 5'h04,
    ST_UVAL = 5'h08,
    ST_MSG  = 5'h10
  } fpc_state_t;

  localparam int unsigned K_EN  = 0;
  localparam int unsigned K_UP  = 1;
  localparam int unsigned K_DN  = 2;
  localparam int unsigned K_POL = 3;
endpackage

//--- fpc_key.sv
// key debouncer with short-press and hold detection
`timescale 1ns/1ps
`default_nettype none
module fpc_key
  import fpc_pkg::*;
#(
  parameter int unsigned DEB  = 2,
  parameter int unsigned HOLD = 4
)(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_key,
  output logic      o_press,
  output logic      o_hold
);
  logic [31:0] deb_cnt;
  logic [31:0] hold_cnt;
  logic        level;
  logic        held;
  logic        flip;

  if (DEB < 1 || HOLD < 1)
    $error("fpc_key: counts too small");

  assign flip = (i_key != level) && (deb_cnt == DEB - 1);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      deb_cnt <= 32'h0;
      level   <= 1'b0;
    end
    else if (i_key == level)
      deb_cnt <= 32'h0;
    else if (flip)
    begin
      deb_cnt <= 32'h0;
      level   <= i_key;
    end
    else
      deb_cnt <= deb_cnt + 32'h1;
  end

  // timed from press onset; a hold swallows the release press [RL22]
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hold_cnt <= 32'h0;
      held     <= 1'b0;
    end
    else if (!level)
    begin
      hold_cnt <= 32'h0;
      held     <= 1'b0;
    end
    else if (!held)
    begin
      if (hold_cnt == HOLD - 1)
        held <= 1'b1;
      else
        hold_cnt <= hold_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_press <= 1'b0;
      o_hold  <= 1'b0;
    end
    else
    begin
      o_press <= flip && level && !held; // [RL22]
      o_hold  <= level && !held && (hold_cnt == HOLD - 1);
    end
  end
endmodule
`default_nettype wire

//--- fpc_operator.sv
// operator model: front-panel keys and host serial transmitter
`timescale 1ns/1ps
`default_nettype none
module fpc_operator
  import fpc_pkg::*;
(
  input  wire logic       i_clk,
  output logic      [3:0] o_key,
  output logic            o_tx
);
  initial
  begin
    o_key = 4'h0;
    o_tx  = 1'b1;
  end

  // raw key high for n edges, then a settle gap so the action lands
  task automatic tap(input int unsigned k, input int n);
    @(posedge i_clk);
    o_key[k] <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_key[k] <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask

  // start, 7 data lsb first, odd parity, stop; bad spoils the parity
  task automatic send(input logic [6:0] ch, input logic bad);
    logic [9:0] f;
    f = {1'b1, ~^ch ^ bad, ch, 1'b0};
    for (int b = 0; b < 10; b++)
    begin
      @(posedge i_clk);
      o_tx <= f[b];
      repeat (BIT_CYC - 1) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the front panel control block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import fpc_pkg::*;
  ;
  localparam int MC = 20;
  localparam int FC = 60;
  logic             I_CLK, I_RST_N, I_NV_PWUP_OPT, I_FACTORY_RESET;
  logic       [3:0] key;
  logic             ser;
  fpc_host_t        I_HOST;
  fpc_nv_t          I_NV_STATE, O_NV_DATA, nv_seen;
  logic             O_OUT_ENABLE, O_OUT_NEG, O_LOCKED, O_PWUP_OPT;
  logic             O_NV_WR, O_RX_VALID, O_RX_ERR, pf, pu;
  logic       [3:0] O_OUT_RANGE;
  fpc_cur_t         O_USER_CUR, cur;
  fpc_disp_t        O_DISP;
  logic       [6:0] O_RX_DATA, rx_d, ch;
  int               fail_count, cmp_count, nv_cnt, n0, rx_ok, rx_bad;

  initial
  begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end

  fpc_panel #(.P_HOLD_CYC(40), .P_MSG_CYC(MC), .P_FLASH_CYC(FC), .P_DEB_CYC(2)) fpc_panel_i (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_KEY_ENABLE(key[K_EN]),
    .I_KEY_UP(key[K_UP]), .I_KEY_DOWN(key[K_DN]), .I_KEY_POL(key[K_POL]),
    .I_HOST(I_HOST), .I_NV_STATE(I_NV_STATE), .I_NV_PWUP_OPT(I_NV_PWUP_OPT),
    .I_FACTORY_RESET(I_FACTORY_RESET), .I_SER_RX(ser), .O_OUT_ENABLE(O_OUT_ENABLE),
    .O_OUT_RANGE(O_OUT_RANGE), .O_OUT_NEG(O_OUT_NEG), .O_USER_CUR(O_USER_CUR),
    .O_DISP(O_DISP), .O_LOCKED(O_LOCKED), .O_PWUP_OPT(O_PWUP_OPT), .O_NV_WR(O_NV_WR),
    .O_NV_DATA(O_NV_DATA), .O_RX_DATA(O_RX_DATA), .O_RX_VALID(O_RX_VALID), .O_RX_ERR(O_RX_ERR)
  );

  fpc_operator fpc_operator_i (.i_clk(I_CLK), .o_key(key), .o_tx(ser));

  // pulses are one cycle wide, so they are caught here rather than polled
  always @(posedge I_CLK)
  begin
    if (O_NV_WR === 1'b1)
    begin
      nv_cnt  <= nv_cnt + 1;
      nv_seen <= O_NV_DATA;
    end
    if (O_RX_VALID === 1'b1)
    begin
      rx_ok <= rx_ok + 1;
      rx_d  <= O_RX_DATA;
    end
    if (O_RX_ERR === 1'b1)
      rx_bad <= rx_bad + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_msg(input fpc_msg_t m);
    chk(32'(O_DISP.msg), 32'(m));
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // bounded wait; running out counts a mismatch and ends the run
  task automatic wait_rng(input logic [3:0] want, input int n);
    int i;
    for (i = 0; i < n && O_OUT_RANGE !== want; i++)
      @(posedge I_CLK);
    chk(32'(O_OUT_RANGE), 32'(want));
    if (i == n)
      final_report();
  endtask

  task automatic host(input fpc_op_t op, input logic [15:0] arg);
    I_HOST <= '{valid: 1'b1, op: op, arg: arg};
    @(posedge I_CLK);
    I_HOST.valid <= 1'b0;
    repeat (3) @(posedge I_CLK);
  endtask

  task automatic reset(input logic opt);
    I_RST_N       <= 1'b0;
    I_NV_PWUP_OPT <= opt;
    repeat (2) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    repeat (4) @(posedge I_CLK);
  endtask

  function automatic fpc_cur_t rnd_cur();
    fpc_cur_t c;
    c.neg  = 1'($urandom);
    c.exp  = 3'($urandom % 6);
    c.mant = 10'(100 + $urandom % 900);
    return c;
  endfunction

  initial
  begin
    I_RST_N         = 1'b0;
    I_HOST          = '0;
    I_FACTORY_RESET = 1'b0;
    I_NV_PWUP_OPT   = 1'b0;
    {fail_count, cmp_count, nv_cnt, rx_ok, rx_bad} = '0;
    void'($urandom(463));
    I_NV_STATE = '{range: 4'($urandom % 13), pol_fixed: 1'($urandom), user: rnd_cur(), en: 1'b1};
    pf = I_NV_STATE.pol_fixed;
    reset(1'b0);
    chk(32'(O_OUT_ENABLE), 0);
    chk(32'(O_OUT_RANGE), 32'(I_NV_STATE.range));
    chk_msg(MSG_OFF);
    done("powerup");
    op_i_glitch: fpc_operator_i.tap(K_EN, 1);
    chk(32'(O_OUT_ENABLE), 0);
    fpc_operator_i.tap(K_EN, 6);
    chk(32'(O_OUT_ENABLE), 1);
    chk_msg(MSG_VALUE);
    fpc_operator_i.tap(K_EN, 6);
    chk(32'(O_OUT_ENABLE), 0);
    chk_msg(MSG_OFF);
    done("enable");
    host(OP_RANGE, 16'h0000);
    for (int i = 1; i <= 14; i++)
    begin
      fpc_operator_i.tap(K_UP, 6);
      chk(32'(O_DISP.range), 32'(i > 13 ? 13 : i));
      chk_msg(i >= 13 ? MSG_USER : MSG_RANGE);
    end
    repeat (MC + 5) @(posedge I_CLK);
    chk_msg(MSG_OFF);
    fpc_operator_i.tap(K_EN, 6);
    chk(32'(O_OUT_RANGE), 32'(RNG_USER));
    host(OP_RANGE, 16'h0000);
    chk(32'(O_OUT_RANGE), 0);
    fpc_operator_i.tap(K_DN, 6);
    chk(32'(O_DISP.range), 0);
    repeat (FC + 10) @(posedge I_CLK);
    chk(32'(O_OUT_RANGE), 0);
    done("ranges");
    host(OP_RANGE, 16'h0003);
    fpc_operator_i.tap(K_UP, 6);
    chk_msg(MSG_RANGE);
    chk(32'(O_DISP.lit), 1);
    repeat (MC / 2) @(posedge I_CLK);
    chk(32'(O_DISP.lit), 0);
    repeat (FC - 30) @(posedge I_CLK);
    chk(32'(O_OUT_RANGE), 3);
    wait_rng(4'h4, 30);
    host(OP_RANGE, 16'h000C);
    fpc_operator_i.tap(K_UP, 6);
    chk_msg(MSG_USER);
    repeat (MC + 5) @(posedge I_CLK);
    chk_msg(MSG_USERVAL);
    chk(32'(O_OUT_RANGE), 12);
    wait_rng(RNG_USER, 2 * MC + 10);
    done("flash");
    pu = O_USER_CUR.neg;
    fpc_operator_i.tap(K_POL, 6);
    pu = ~pu;
    chk(32'(O_OUT_NEG), 32'(pu));
    host(OP_RANGE, 16'h0005);
    chk(32'(O_OUT_NEG), 32'(pf));
    fpc_operator_i.tap(K_POL, 6);
    pf = ~pf;
    chk(32'(O_OUT_NEG), 32'(pf));
    chk(32'(O_OUT_RANGE), 5);
    done("polarity");
    cur = rnd_cur();
    host(OP_USER, {2'h0, cur});
    chk(32'(O_USER_CUR), 32'(cur));
    cur = '{neg: 1'b1, exp: EXP_MAX, mant: MANT_MIN};
    host(OP_USER, {2'h0, cur});
    host(OP_USER, {2'h0, 1'b0, 3'h7, MANT_MIN});
    chk(32'(O_USER_CUR), 32'(cur));
    n0 = nv_cnt;
    fpc_operator_i.tap(K_POL, 46);
    chk(32'(nv_cnt != n0), 1);
    chk(32'(nv_seen.range), 5);
    chk(32'(nv_seen.pol_fixed), 32'(pf));
    chk(32'(nv_seen.user), 32'(cur));
    chk(32'(O_OUT_NEG), 32'(pf));
    I_FACTORY_RESET <= 1'b1;
    @(posedge I_CLK);
    I_FACTORY_RESET <= 1'b0;
    repeat (3) @(posedge I_CLK);
    chk(32'(nv_seen.range), 32'(RNG_MIN));
    chk(32'(nv_seen.pol_fixed), 0);
    chk(32'(nv_seen.user), 32'(RST_USER));
    done("save");
    fpc_operator_i.tap(K_EN, 46);
    chk(32'(O_LOCKED), 1);
    chk_msg(MSG_LOCKED);
    chk(32'(O_OUT_ENABLE), 1);
    repeat (MC) @(posedge I_CLK);
    fpc_operator_i.tap(K_DN, 6);
    chk_msg(MSG_LOCKED);
    fpc_operator_i.tap(K_POL, 6);
    repeat (MC + 5) @(posedge I_CLK);
    chk_msg(MSG_VALUE);
    chk(32'(O_OUT_RANGE), 5);
    chk(32'(O_OUT_NEG), 32'(pf));
    fpc_operator_i.tap(K_EN, 46);
    chk(32'(O_LOCKED), 0);
    chk_msg(MSG_UNLOCKED);
    done("lock");
    host(OP_ENABLE, 16'h0000);
    chk(32'(O_OUT_ENABLE), 0);
    chk_msg(MSG_OFF);
    host(OP_POL, 16'h0001);
    chk(32'(O_OUT_NEG), 1);
    host(OP_LOCK, 16'h0001);
    chk(32'(O_LOCKED), 1);
    host(OP_LOCK, 16'h0000);
    chk(32'(O_LOCKED), 0);
    host(OP_PWUP, 16'h0001);
    chk(32'(O_PWUP_OPT), 1);
    n0 = nv_cnt;
    host(OP_SAVE, 16'h0000);
    chk(32'(nv_cnt - n0), 1);
    chk(32'(nv_seen.pol_fixed), 1);
    chk(32'(nv_seen.en), 0);
    host(OP_ENABLE, 16'h0001);
    chk(32'(O_OUT_ENABLE), 1);
    done("host");
    ch = 7'($urandom);
    fpc_operator_i.send(ch, 1'b0);
    fpc_operator_i.send(~ch, 1'b1);
    chk(32'(rx_ok), 1);
    chk(32'(rx_d), 32'(ch));
    chk(32'(rx_bad), 1);
    done("serial");
    reset(1'b1);
    chk(32'(O_OUT_ENABLE), 1);
    chk(32'(O_PWUP_OPT), 1);
    chk(32'(O_LOCKED), 0);
    done("option");
    final_report();
  end
endmodule
`default_nettype wire
